// >>> include/uart_dma_pkg.sv
/*
 * shared constants and carriers for the uart dma, break and bit-rate block.
 * assumes a 25 MHz system clock and a 32-bit apb register bus.
 */
package uart_dma_pkg;

    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned ADDR_W        = 8;

    // register byte offsets
    localparam logic [7:0] OFS_FIFO_CTL   = 8'h00;
    localparam logic [7:0] OFS_LINE_CTL   = 8'h04;
    localparam logic [7:0] OFS_MODEM_CTL  = 8'h08;
    localparam logic [7:0] OFS_DIV_LOW    = 8'h0c;
    localparam logic [7:0] OFS_DIV_HIGH   = 8'h10;
    localparam logic [7:0] OFS_FRAC_CTL   = 8'h14;
    localparam logic [7:0] OFS_SAMPLE_ADJ = 8'h18;
    localparam logic [7:0] OFS_TRIGGER    = 8'h1c;
    localparam logic [7:0] OFS_STATUS     = 8'h20;

    // field positions
    localparam int unsigned FCR_FIFO_EN   = 0;
    localparam int unsigned FCR_DMA_MODE  = 3;
    localparam int unsigned LCR_PAR_EN    = 3;
    localparam int unsigned LCR_STOP2     = 2;
    localparam int unsigned LCR_BREAK     = 6;
    localparam int unsigned MCR_PRESC4    = 7;
    localparam int unsigned DLD_RATE4     = 5;
    localparam int unsigned DLD_RATE8     = 4;
    localparam int unsigned TRG_RX_LSB    = 8;
    localparam int unsigned ST_TIMEOUT    = 0;
    localparam int unsigned ST_BREAK      = 1;
    localparam int unsigned ST_TX_REQ     = 2;
    localparam int unsigned ST_RX_REQ     = 3;

    // reset values
    localparam logic [7:0] RST_REG8       = 8'h00;
    localparam logic [7:0] RST_LINE_CTL   = 8'h1d;
    localparam logic [7:0] RST_DIV_LOW    = 8'h01;
    localparam logic [7:0] RST_DIV_HIGH   = 8'h00;

    // timing counts
    localparam logic [1:0] PRESC_LAST     = 2'h3;
    localparam logic [4:0] RATE_BASE      = 5'h10;
    localparam logic [4:0] RATE_FOUR      = 5'h04;
    localparam logic [4:0] RATE_EIGHT     = 5'h08;
    localparam logic [3:0] DATA_BITS_MIN  = 4'h5;
    localparam logic [5:0] TIMEOUT_CHARS  = 6'h04;

    // status from the fifo and receiver core, same clock
    typedef struct packed {
        logic       tx_empty;
        logic       tx_full;
        logic [6:0] tx_free;
        logic [6:0] rx_level;
        logic       rx_stop_mid;
        logic       rx_read;
        logic       rx_error;
    } fifo_stat_t;

    typedef struct packed {
        logic [1:0]  presc_cnt;
        logic [15:0] div_cnt;
        logic [4:0]  samp_cnt;
        logic        sample_tick;
        logic        bit_tick;
    } baud_state_t;

    typedef struct packed {
        logic [7:0]  fifo_ctl;
        logic [7:0]  line_ctl;
        logic [7:0]  modem_ctl;
        logic [7:0]  frac_ctl;
        logic [7:0]  sample_adj;
        logic [6:0]  tx_trig;
        logic [6:0]  rx_trig;
        logic        rx_s1;
        logic        rx_s2;
        logic [5:0]  tmo_cnt;
        logic        tmo_flag;
        logic [4:0]  brk_cnt;
        logic        brk_flag;
        logic        tx_blk;
        logic        rx_blk;
        logic        tx_req_n;
        logic        rx_req_n;
        logic        txd;
        logic [31:0] rdata;
    } main_state_t;

endpackage

// >>> src/baud_gen.sv
/*
 * bit-rate generator: prescaler, 16-bit divisor and sample-rate counter.
 * assumes divisor and rate are stable or changed between characters.
 */
`timescale 1ns/1ps
module baud_gen
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        arst_n_i,
    input  wire logic        ce_i,
    // configuration
    input  wire logic [15:0] divisor_i,
    input  wire logic        presc4_i,
    input  wire logic [4:0]  rate_i,
    // ticks
    output logic             sample_tick_o,
    output logic             bit_tick_o
);

    uart_dma_pkg::baud_state_t s_q;
    uart_dma_pkg::baud_state_t s_d;
    logic                      pre_tick;
    logic                      div_tick;

    always_comb
    begin
        s_d = s_q;
        s_d.sample_tick = 1'b0;
        s_d.bit_tick = 1'b0;
        s_d.presc_cnt = presc4_i ? s_q.presc_cnt + 2'h1 : 2'h0;
        pre_tick = !presc4_i || (s_q.presc_cnt == uart_dma_pkg::PRESC_LAST);
        div_tick = 1'b0;
        if (divisor_i == 16'h0000)
        begin
            s_d.div_cnt = 16'h0000;
            s_d.samp_cnt = 5'h00;
        end
        else if (pre_tick)
        begin
            if (s_q.div_cnt >= divisor_i - 16'h0001)
            begin
                s_d.div_cnt = 16'h0000;
                div_tick = 1'b1;
            end
            else
            begin
                s_d.div_cnt = s_q.div_cnt + 16'h0001;
            end
        end
        if (div_tick)
        begin
            s_d.sample_tick = 1'b1;
            if (s_q.samp_cnt >= rate_i - 5'h01)
            begin
                s_d.samp_cnt = 5'h00;
                s_d.bit_tick = 1'b1;
            end
            else
            begin
                s_d.samp_cnt = s_q.samp_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            s_q <= '0;
        else if (ce_i)
            s_q <= s_d;
    end

    assign sample_tick_o = s_q.sample_tick;
    assign bit_tick_o    = s_q.bit_tick;

    no_clock_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        ce_i && divisor_i == 16'h0000 |=> !sample_tick_o)
        else $error("tick with zero divisor");

    bit_rate_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        ce_i && bit_tick_o |-> sample_tick_o)
        else $error("bit tick without sample tick");

endmodule // baud_gen

// >>> src/uart_dma_break_baud_gen.sv
/*
 * dma request signalling, receive time-out, break detect and send, bit-rate
 * control registers of one uart channel, reached over apb.
 * assumes fifo status comes from logic on clock_i and rx_pin_i is asynchronous.
 */
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module uart_dma_break_baud_gen
(
    // clock and resets
    input  wire logic                    clock_i,
    input  wire logic                    arst_n_i,
    input  wire logic                    por_n_i,
    input  wire logic                    ce_i,
    // apb slave
    input  wire logic [7:0]              paddr_i,
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [31:0]             pwdata_i,
    output logic [31:0]                  prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    // fifo and receiver status
    input  wire uart_dma_pkg::fifo_stat_t fifo_i,
    // serial line
    input  wire logic                    rx_pin_i,
    input  wire logic                    tx_serial_i,
    output logic                         tx_pin_o,
    // dma requests
    output logic                         tx_dma_request_n_o,
    output logic                         rx_dma_request_n_o,
    // bit-rate and events
    output logic                         sample_tick_o,
    output logic                         bit_tick_o,
    output logic                         break_detect_o,
    output logic                         rx_timeout_o
);

    uart_dma_pkg::main_state_t s_q;
    uart_dma_pkg::main_state_t s_d;
    logic [7:0]                div_low_q;
    logic [7:0]                div_high_q;
    logic [15:0]               divisor;
    logic [4:0]                rate;
    logic [3:0]                frame_bits;
    logic [5:0]                tmo_limit;
    logic                      single_mode;
    logic                      wr_en;
    logic                      rd_setup;
    logic                      mapped;
    logic                      tmo_hit;
    logic                      rx_low;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    always_comb
    begin
        unique case (paddr_i)
            uart_dma_pkg::OFS_FIFO_CTL,
            uart_dma_pkg::OFS_LINE_CTL,
            uart_dma_pkg::OFS_MODEM_CTL,
            uart_dma_pkg::OFS_DIV_LOW,
            uart_dma_pkg::OFS_DIV_HIGH,
            uart_dma_pkg::OFS_FRAC_CTL,
            uart_dma_pkg::OFS_SAMPLE_ADJ,
            uart_dma_pkg::OFS_TRIGGER,
            uart_dma_pkg::OFS_STATUS: mapped = 1'b1;
            default:                  mapped = 1'b0;
        endcase
    end

    assign pready_o  = ce_i;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign wr_en     = psel_i && penable_i && pwrite_i && mapped && ce_i;
    assign rd_setup  = psel_i && !penable_i && !pwrite_i;

    ////////////////////////////////////////////////////////////////////////////
    // divisor bytes, kept across device reset, loaded with 0x0001 only at power-on

    always_ff @(posedge clock_i or negedge por_n_i)
    begin
        if (!por_n_i)
        begin
            div_low_q  <= uart_dma_pkg::RST_DIV_LOW;
            div_high_q <= uart_dma_pkg::RST_DIV_HIGH;
        end
        else if (wr_en && paddr_i == uart_dma_pkg::OFS_DIV_LOW)
        begin
            div_low_q <= pwdata_i[7:0];
        end
        else if (wr_en && paddr_i == uart_dma_pkg::OFS_DIV_HIGH)
        begin
            div_high_q <= pwdata_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit-rate configuration

    assign divisor = {div_high_q, div_low_q};

    always_comb
    begin
        if (s_q.frac_ctl[uart_dma_pkg::DLD_RATE4])
            rate = uart_dma_pkg::RATE_FOUR;
        else if (s_q.frac_ctl[uart_dma_pkg::DLD_RATE8])
            rate = uart_dma_pkg::RATE_EIGHT;
        else
            rate = uart_dma_pkg::RATE_BASE - {1'b0, s_q.sample_adj[3:0]} + {1'b0, s_q.sample_adj[7:4]};
    end

    // one generator feeds both directions
    baud_gen u_baud_gen
    (
        .clock_i       (clock_i),
        .arst_n_i      (arst_n_i),
        .ce_i          (ce_i),
        .divisor_i     (divisor),
        .presc4_i      (s_q.modem_ctl[uart_dma_pkg::MCR_PRESC4]),
        .rate_i        (rate),
        .sample_tick_o (sample_tick_o),
        .bit_tick_o    (bit_tick_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // frame length and derived counts

    always_comb
    begin
        frame_bits = 4'h1 + uart_dma_pkg::DATA_BITS_MIN + {2'b00, s_q.line_ctl[1:0]}
                   + {3'b000, s_q.line_ctl[uart_dma_pkg::LCR_PAR_EN]}
                   + (s_q.line_ctl[uart_dma_pkg::LCR_STOP2] ? 4'h2 : 4'h1);
        tmo_limit  = 6'(frame_bits * uart_dma_pkg::TIMEOUT_CHARS);
    end

    assign single_mode = !s_q.fifo_ctl[uart_dma_pkg::FCR_DMA_MODE] || !s_q.fifo_ctl[uart_dma_pkg::FCR_FIFO_EN];
    assign rx_low      = !s_q.rx_s2;
    assign tmo_hit     = (s_q.tmo_cnt == tmo_limit) && fifo_i.rx_level != 7'h00
                       && fifo_i.rx_level < s_q.rx_trig && s_q.fifo_ctl[uart_dma_pkg::FCR_FIFO_EN]
                       && !s_q.tmo_flag;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        s_d = s_q;
        s_d.rx_s1 = rx_pin_i;
        s_d.rx_s2 = s_q.rx_s1;
        if (wr_en)
        begin
            unique case (paddr_i)
                uart_dma_pkg::OFS_FIFO_CTL:   s_d.fifo_ctl   = pwdata_i[7:0];
                uart_dma_pkg::OFS_LINE_CTL:   s_d.line_ctl   = pwdata_i[7:0];
                uart_dma_pkg::OFS_MODEM_CTL:  s_d.modem_ctl  = pwdata_i[7:0];
                uart_dma_pkg::OFS_FRAC_CTL:   s_d.frac_ctl   = pwdata_i[7:0];
                uart_dma_pkg::OFS_SAMPLE_ADJ: s_d.sample_adj = pwdata_i[7:0];
                uart_dma_pkg::OFS_TRIGGER:
                begin
                    s_d.tx_trig = pwdata_i[6:0];
                    s_d.rx_trig = pwdata_i[uart_dma_pkg::TRG_RX_LSB +: 7];
                end
                default: s_d.rdata = s_q.rdata;
            endcase
        end
        // read data captured in the setup phase
        if (rd_setup)
        begin
            s_d.rdata = 32'h0000_0000;
            unique case (paddr_i)
                uart_dma_pkg::OFS_FIFO_CTL:   s_d.rdata[7:0] = s_q.fifo_ctl;
                uart_dma_pkg::OFS_LINE_CTL:   s_d.rdata[7:0] = s_q.line_ctl;
                uart_dma_pkg::OFS_MODEM_CTL:  s_d.rdata[7:0] = s_q.modem_ctl;
                uart_dma_pkg::OFS_DIV_LOW:    s_d.rdata[7:0] = div_low_q;
                uart_dma_pkg::OFS_DIV_HIGH:   s_d.rdata[7:0] = div_high_q;
                uart_dma_pkg::OFS_FRAC_CTL:   s_d.rdata[7:0] = s_q.frac_ctl;
                uart_dma_pkg::OFS_SAMPLE_ADJ: s_d.rdata[7:0] = s_q.sample_adj;
                uart_dma_pkg::OFS_TRIGGER:
                begin
                    s_d.rdata[6:0] = s_q.tx_trig;
                    s_d.rdata[uart_dma_pkg::TRG_RX_LSB +: 7] = s_q.rx_trig;
                end
                uart_dma_pkg::OFS_STATUS:
                begin
                    s_d.rdata[uart_dma_pkg::ST_TIMEOUT] = s_q.tmo_flag;
                    s_d.rdata[uart_dma_pkg::ST_BREAK]   = s_q.brk_flag;
                    s_d.rdata[uart_dma_pkg::ST_TX_REQ]  = !s_q.tx_req_n;
                    s_d.rdata[uart_dma_pkg::ST_RX_REQ]  = !s_q.rx_req_n;
                end
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        // receive time-out
        if (fifo_i.rx_stop_mid || fifo_i.rx_read)
            s_d.tmo_cnt = 6'h00;
        else if (bit_tick_o && fifo_i.rx_level != 7'h00 && s_q.tmo_cnt != tmo_limit)
            s_d.tmo_cnt = s_q.tmo_cnt + 6'h01;
        s_d.tmo_flag = tmo_hit || (s_q.tmo_flag && !fifo_i.rx_read);

        // break detect on the synchronised line
        if (!rx_low)
        begin
            s_d.brk_cnt  = 5'h00;
            s_d.brk_flag = 1'b0;
        end
        else if (bit_tick_o && !s_q.brk_flag)
        begin
            s_d.brk_cnt = s_q.brk_cnt + 5'h01;
            if (s_q.brk_cnt == {1'b0, frame_bits})
                s_d.brk_flag = 1'b1;
        end

        // block-mode request latches
        if (fifo_i.tx_full)
            s_d.tx_blk = 1'b0;
        else if (fifo_i.tx_free >= s_q.tx_trig)
            s_d.tx_blk = 1'b1;
        if (fifo_i.rx_level == 7'h00 || fifo_i.rx_error)
            s_d.rx_blk = 1'b0;
        else if (fifo_i.rx_level >= s_q.rx_trig || s_q.tmo_flag)
            s_d.rx_blk = 1'b1;

        if (single_mode)
        begin
            s_d.tx_req_n = !fifo_i.tx_empty;
            s_d.rx_req_n = fifo_i.rx_level == 7'h00;
        end
        else
        begin
            s_d.tx_req_n = !s_d.tx_blk;
            s_d.rx_req_n = !s_d.rx_blk;
        end

        s_d.txd = tx_serial_i && !s_q.line_ctl[uart_dma_pkg::LCR_BREAK];
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s_q          <= '0;
            s_q.line_ctl <= uart_dma_pkg::RST_LINE_CTL;
            s_q.rx_s1    <= 1'b1;
            s_q.rx_s2    <= 1'b1;
            s_q.rx_req_n <= 1'b1;
            s_q.txd      <= 1'b1;
        end
        else if (ce_i)
        begin
            s_q <= s_d;
        end
    end

    assign prdata_o           = s_q.rdata;
    assign tx_pin_o           = s_q.txd;
    assign tx_dma_request_n_o = s_q.tx_req_n;
    assign rx_dma_request_n_o = s_q.rx_req_n;
    assign break_detect_o     = s_q.brk_flag;
    assign rx_timeout_o       = s_q.tmo_flag;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence apb_write_line;
        psel_i && !penable_i && pwrite_i && paddr_i == uart_dma_pkg::OFS_LINE_CTL && ce_i
        ##1 psel_i && penable_i && ce_i;
    endsequence

    break_send_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        apb_write_line ##0 pwdata_i[uart_dma_pkg::LCR_BREAK] ##1 ce_i [*2] |=> !tx_pin_o)
        else $error("break not sent");

    tx_single_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        ce_i && single_mode && fifo_i.tx_empty |=> !tx_dma_request_n_o)
        else $error("tx request missing");

    rx_single_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        ce_i && single_mode && fifo_i.rx_level == 7'h00 |=> rx_dma_request_n_o)
        else $error("rx request while empty");

    tx_block_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        ce_i && !single_mode && fifo_i.tx_full |=> tx_dma_request_n_o)
        else $error("tx request while full");

    rx_block_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        ce_i && !single_mode && fifo_i.rx_error |=> rx_dma_request_n_o)
        else $error("rx request on error");

    tmo_restart_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        ce_i && fifo_i.rx_stop_mid |=> s_q.tmo_cnt == 6'h00)
        else $error("time-out not restarted");

    tmo_clear_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        ce_i && fifo_i.rx_read && !tmo_hit |=> !rx_timeout_o)
        else $error("time-out not cleared");

    break_len_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        $rose(break_detect_o) |-> $past(s_q.brk_cnt) == {1'b0, frame_bits} && rx_low)
        else $error("break flagged early");

    presc_reset_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        $rose(arst_n_i) |-> !s_q.modem_ctl[uart_dma_pkg::MCR_PRESC4])
        else $error("prescaler not divide by one");

    tmo_set_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        ce_i && !rx_timeout_o && s_q.tmo_cnt == tmo_limit && fifo_i.rx_level != 7'h00
        && fifo_i.rx_level < s_q.rx_trig && s_q.fifo_ctl[uart_dma_pkg::FCR_FIFO_EN] |=> rx_timeout_o)
        else $error("time-out not raised");

    tmo_hold_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        ce_i && rx_timeout_o && !fifo_i.rx_read |=> rx_timeout_o)
        else $error("time-out dropped without read");

    brk_clear_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        ce_i && !rx_low |=> !break_detect_o)
        else $error("break held on idle line");

    tx_pass_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        ce_i && !s_q.line_ctl[uart_dma_pkg::LCR_BREAK] |=> tx_pin_o == $past(tx_serial_i))
        else $error("serial output not passed through");

    tx_single_clr_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        ce_i && single_mode && !fifo_i.tx_empty |=> tx_dma_request_n_o)
        else $error("tx request after load");

    rx_block_set_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        ce_i && !single_mode && fifo_i.rx_level != 7'h00 && fifo_i.rx_level >= s_q.rx_trig
        && !fifo_i.rx_error |=> !rx_dma_request_n_o)
        else $error("rx request missing at trigger");

endmodule // uart_dma_break_baud_gen

// >>> tb/fifo_model.sv
/* far-side fifo core stand-in: turns fill counts into status.
   assumes the bench drives the counts just after clock edges. */
`timescale 1ns/1ps
module fifo_model
#(
    parameter int unsigned DEPTH = 64
)
(
    // fill counts and events
    input  wire logic [6:0]   tx_used_i,
    input  wire logic [6:0]   rx_used_i,
    input  wire logic         stop_mid_i,
    input  wire logic         read_i,
    input  wire logic         error_i,
    // status
    output uart_dma_pkg::fifo_stat_t stat_o
);
    always_comb
    begin
        stat_o.tx_empty    = (tx_used_i == 7'h00);
        stat_o.tx_full     = (tx_used_i >= 7'(DEPTH));
        stat_o.tx_free     = 7'(DEPTH) - tx_used_i;
        stat_o.rx_level    = rx_used_i;
        stat_o.rx_stop_mid = stop_mid_i;
        stat_o.rx_read     = read_i;
        stat_o.rx_error    = error_i;
    end
endmodule // fifo_model

// >>> tb/tb_top.sv
/* self-checking bench: dma requests, baud ticks, break and time-out.
   assumes one-cycle apb access while ce_i is high. */
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [7:0] fifo_control_reg;
        logic [6:0] txl;
        logic [6:0] rxl;
        logic       err;
        logic       etx;
        logic       erx;
    } dma_row_t;
    typedef struct packed {
        logic [7:0]  modem_control_reg;
        logic [7:0]  dl;
        logic [7:0]  dh;
        logic [7:0]  frac;
        logic [7:0]  adj;
        logic [15:0] per;
    } baud_row_t;
    logic        clock_i = 1'b0;
    logic        arst_n = 1'b0;
    logic        por_n = 1'b0;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        rx_pin = 1'b1;
    logic        tx_ser = 1'b1;
    logic [6:0]  tx_used = 7'h00;
    logic [6:0]  rx_used = 7'h00;
    logic        smid = 1'b0;
    logic        rrd = 1'b0;
    logic        rerr = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tx_pin;
    logic        tx_rq_n;
    logic        rx_rq_n;
    logic        stk;
    logic        btk;
    logic        brk;
    logic        tmo;
    logic [31:0] q;
    logic        e;
    logic [15:0] gap;
    uart_dma_pkg::fifo_stat_t stat;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          cyc = 0;
    dma_row_t    dt [0:10] = '{'{8'h00, 7'd0, 7'd0, 1'b0, 1'b0, 1'b1}, '{8'h00, 7'd1, 7'd0, 1'b0, 1'b1, 1'b1},
                               '{8'h00, 7'd0, 7'd1, 1'b0, 1'b0, 1'b0}, '{8'h01, 7'd64, 7'd5, 1'b0, 1'b1, 1'b0},
                               '{8'h08, 7'd0, 7'd0, 1'b0, 1'b0, 1'b1}, '{8'h09, 7'd64, 7'd3, 1'b0, 1'b1, 1'b1},
                               '{8'h09, 7'd56, 7'd3, 1'b0, 1'b0, 1'b1}, '{8'h09, 7'd60, 7'd4, 1'b0, 1'b0, 1'b0},
                               '{8'h09, 7'd64, 7'd2, 1'b0, 1'b1, 1'b0}, '{8'h09, 7'd60, 7'd2, 1'b1, 1'b1, 1'b1},
                               '{8'h09, 7'd60, 7'd0, 1'b0, 1'b1, 1'b1}};
    baud_row_t   bt [0:4] = '{'{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 16'd16}, '{8'h80, 8'h03, 8'h00, 8'h20, 8'h00, 16'd48},
                              '{8'h00, 8'h02, 8'h00, 8'h10, 8'h00, 16'd16}, '{8'h00, 8'h01, 8'h00, 8'h00, 8'h32, 16'd17},
                              '{8'h00, 8'h00, 8'h01, 8'h20, 8'h00, 16'd1024}};

    ////////////////////////////////////////////////////////////////
    fifo_model i_fifo (.tx_used_i(tx_used), .rx_used_i(rx_used), .stop_mid_i(smid), .read_i(rrd),
                       .error_i(rerr), .stat_o(stat));
    uart_dma_break_baud_gen i_dut (.clock_i(clock_i), .arst_n_i(arst_n), .por_n_i(por_n), .ce_i(ce),
        .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .fifo_i(stat), .rx_pin_i(rx_pin),
        .tx_serial_i(tx_ser), .tx_pin_o(tx_pin), .tx_dma_request_n_o(tx_rq_n), .rx_dma_request_n_o(rx_rq_n),
        .sample_tick_o(stk), .bit_tick_o(btk), .break_detect_o(brk), .rx_timeout_o(tmo));

    ////////////////////////////////////////////////////////////////
    initial
    begin
        forever #20 clock_i = ~clock_i;
    end
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    task end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1) @(posedge clock_i);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task pulse(input logic rd_ev);
        @(posedge clock_i);
        smid <= !rd_ev;
        rrd <= rd_ev;
        @(posedge clock_i);
        smid <= 1'b0;
        rrd <= 1'b0;
    endtask
    task tick_gap();
        @(negedge clock_i);
        while (btk !== 1'b1) @(negedge clock_i);
        @(negedge clock_i);
        gap = 16'd1;
        while (btk !== 1'b1)
        begin
            @(negedge clock_i);
            gap++;
        end
    endtask
    // sel: 0 serial output, 1 break flag, 2 time-out flag
    task idle(input int n, input int sel, input logic exp);
        repeat (n) @(negedge clock_i);
        chk(32'(sel == 0 ? tx_pin : sel == 1 ? brk : tmo), 32'(exp));
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(negedge clock_i);
        chk(32'({tx_pin, tx_rq_n, rx_rq_n}), 32'h5);
        @(posedge clock_i);
        arst_n <= 1'b1;
        por_n <= 1'b1;
        rd(uart_dma_pkg::OFS_LINE_CTL, 32'h1d);
        rd(uart_dma_pkg::OFS_DIV_LOW, 32'h01);
        rd(uart_dma_pkg::OFS_MODEM_CTL, 32'h00);
        apb(1'b1, uart_dma_pkg::OFS_TRIGGER, 32'h0408);
        for (int i = 0; i <= 10; i++)
        begin
            apb(1'b1, uart_dma_pkg::OFS_FIFO_CTL, 32'(dt[i].fifo_control_reg));
            tx_used <= dt[i].txl;
            rx_used <= dt[i].rxl;
            rerr <= dt[i].err;
            repeat (3) @(negedge clock_i);
            chk(32'(tx_rq_n), 32'(dt[i].etx));
            chk(32'(rx_rq_n), 32'(dt[i].erx));
        end
        for (int i = 0; i <= 4; i++)
        begin
            apb(1'b1, uart_dma_pkg::OFS_MODEM_CTL, 32'(bt[i].modem_control_reg));
            apb(1'b1, uart_dma_pkg::OFS_DIV_LOW, 32'(bt[i].dl));
            apb(1'b1, uart_dma_pkg::OFS_DIV_HIGH, 32'(bt[i].dh));
            apb(1'b1, uart_dma_pkg::OFS_FRAC_CTL, 32'(bt[i].frac));
            apb(1'b1, uart_dma_pkg::OFS_SAMPLE_ADJ, 32'(bt[i].adj));
            tick_gap();
            tick_gap();
            chk(32'(gap), 32'(bt[i].per));
        end
        apb(1'b1, uart_dma_pkg::OFS_DIV_HIGH, 32'h0);
        @(posedge clock_i);
        e = 1'b0;
        repeat (300)
        begin
            @(negedge clock_i);
            e = e | btk | stk;
        end
        chk(32'(e), 32'h0);
        apb(1'b1, uart_dma_pkg::OFS_DIV_LOW, 32'h01);
        @(posedge clock_i);
        ce <= 1'b0;
        @(negedge clock_i);
        q = 32'({stk, btk});
        e = pready;
        repeat (50)
        begin
            @(negedge clock_i);
            e = e | pready | (32'({stk, btk}) != q);
        end
        chk(32'(e), 32'h0);
        @(posedge clock_i);
        ce <= 1'b1;
        apb(1'b1, uart_dma_pkg::OFS_LINE_CTL, 32'h40);
        idle(3, 0, 1'b0);
        apb(1'b1, uart_dma_pkg::OFS_LINE_CTL, 32'h00);
        idle(3, 0, 1'b1);
        @(posedge clock_i);
        tx_ser <= 1'b0;
        idle(3, 0, 1'b0);
        @(posedge clock_i);
        tx_ser <= 1'b1;
        rx_pin <= 1'b0;
        idle(24, 1, 1'b0);
        idle(28, 1, 1'b1);
        @(posedge clock_i);
        rx_pin <= 1'b1;
        idle(5, 1, 1'b0);
        apb(1'b1, uart_dma_pkg::OFS_FIFO_CTL, 32'h01);
        rx_used <= 7'd2;
        pulse(1'b0);
        idle(80, 2, 1'b0);
        pulse(1'b0);
        idle(90, 2, 1'b0);
        idle(60, 2, 1'b1);
        rd(uart_dma_pkg::OFS_STATUS, 32'h09);
        pulse(1'b1);
        idle(3, 2, 1'b0);
        apb(1'b1, uart_dma_pkg::OFS_DIV_LOW, 32'h05);
        apb(1'b0, 8'hfc, 32'h0);
        chk(32'(e), 32'h1);
        chk(q, 32'h0);
        @(posedge clock_i);
        arst_n <= 1'b0;
        repeat (2) @(posedge clock_i);
        arst_n <= 1'b1;
        rd(uart_dma_pkg::OFS_DIV_LOW, 32'h05);
        rd(uart_dma_pkg::OFS_LINE_CTL, 32'h1d);
        end_of_test();
    end
endmodule // tb_top
